// File: pbpc_bist_ctrl.sv
// BIST packet generator and PRBS checker control with AXI4-Lite registers
// What this block does
// - Packet counter overflow sets status bit 10
// - Byte counter overflow sets status bit 9
// - Overflow flags stay until counters cleared
// - Eight-bit error byte count in bits 7:0
// - Mode zero: error count saturates at maximum
// - Writing bit 0 locks counter readouts
// - Writing bit 1 locks and clears counters
// - Packet length register sets payload bytes
// - Thirteen 0x5 nibbles then 0xD5 delimiter
// - Gap field sets idle between packets
// - Each gap unit adds four bytes
// - Byte counter locks and saturates in mode zero
`timescale 1ns/10ps
module pbpc_bist_ctrl (
  input  wire logic        aclk,      // 20 MHz clock
  input  wire logic        aresetn,   // Synchronous reset, low
  input  wire logic [31:0] awaddr,    // Write address
  input  wire logic        awvalid,   // Write address valid
  output logic             awready,   // Write address ready
  input  wire logic [31:0] wdata,     // Write data
  input  wire logic [3:0]  wstrb,     // Write byte strobes
  input  wire logic        wvalid,    // Write data valid
  output logic             wready,    // Write data ready
  output logic [1:0]       bresp,     // Write response
  output logic             bvalid,    // Write response valid
  input  wire logic        bready,    // Write response ready
  input  wire logic [31:0] araddr,    // Read address
  input  wire logic        arvalid,   // Read address valid
  output logic             arready,   // Read address ready
  output logic [31:0]      rdata,     // Read data
  output logic [1:0]       rresp,     // Read response
  output logic             rvalid,    // Read data valid
  input  wire logic        rready,    // Read data ready
  output logic             gen_valid, // Generated nibble valid
  input  wire logic        gen_ready, // Receiver takes nibble
  output logic [3:0]       gen_data,  // Generated nibble
  output logic             gen_frame, // Nibble belongs to a frame
  input  wire logic        chk_valid, // Received byte valid
  input  wire logic        chk_first, // First payload byte of packet
  input  wire logic        chk_last,  // Last payload byte of packet
  input  wire logic [7:0]  chk_data   // Received payload byte
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [15:0] pkt_len;
  logic [7:0]  gap_len;
  logic [1:0]  control;
  logic [15:0] snap_byte;
  logic [7:0]  snap_err;
  logic [15:0] snap_pkt;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  logic        aw_held;
  logic [7:0]  aw_idx;
  logic        aw_ok;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire do_write = aw_held & w_held & ~bvalid;
  wire lo_en    = do_write & w_strb[0];
  wire hi_en    = do_write & w_strb[1];

  assign awready = ~aw_held & ~bvalid;
  assign wready  = ~w_held & ~bvalid;

  wire aw_aligned = (awaddr[1:0] == 2'h0) & (awaddr[31:10] == 22'h0);
  wire aw_mapped  = aw_aligned & ((awaddr[9:2] == pbpc_pkg::IDX_CONTROL) |
                                  (awaddr[9:2] == pbpc_pkg::IDX_STATUS) |
                                  (awaddr[9:2] == pbpc_pkg::IDX_PKT_LEN) |
                                  (awaddr[9:2] == pbpc_pkg::IDX_GAP_LEN));

  wire wr_status  = aw_idx == pbpc_pkg::IDX_STATUS;
  wire wr_pkt_len = aw_idx == pbpc_pkg::IDX_PKT_LEN;
  wire wr_gap_len = aw_idx == pbpc_pkg::IDX_GAP_LEN;
  wire wr_control = aw_idx == pbpc_pkg::IDX_CONTROL;

  wire lock_strobe  = lo_en & aw_ok & wr_status &
                      (w_data[pbpc_pkg::STS_LOCK_BIT] | w_data[pbpc_pkg::STS_CLEAR_BIT]);
  wire clear_strobe = lo_en & aw_ok & wr_status & w_data[pbpc_pkg::STS_CLEAR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= 8'h00;
      aw_ok   <= 1'b0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= pbpc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx  <= awaddr[9:2];
        aw_ok   <= aw_mapped;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= aw_ok ? pbpc_pkg::RESP_OKAY : pbpc_pkg::RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_len <= pbpc_pkg::PKT_LEN_RST;
      gap_len <= pbpc_pkg::GAP_LEN_RST;
      control <= pbpc_pkg::CONTROL_RST;
    end else if (aw_ok) begin
      if (lo_en & wr_pkt_len) begin
        pkt_len[7:0] <= w_data[7:0];
      end
      if (hi_en & wr_pkt_len) begin
        pkt_len[15:8] <= w_data[15:8];
      end
      if (lo_en & wr_gap_len) begin
        gap_len <= w_data[7:0];
      end
      if (lo_en & wr_control) begin
        control <= w_data[1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checker counters
  // ---------------------------------------------------------------------------
  logic [6:0]  chk_prbs;
  logic [15:0] byte_count;
  logic [7:0]  err_count;
  logic [15:0] pkt_count;
  logic        byte_ovf;
  logic        pkt_ovf;

  wire        wrap_en  = control[pbpc_pkg::CTL_MODE_BIT];
  wire [14:0] chk_step = pbpc_pkg::pbpc_prbs_step(chk_first ? pbpc_pkg::PRBS_SEED : chk_prbs);
  wire        err_inc  = chk_valid & (chk_data != chk_step[14:7]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_prbs <= pbpc_pkg::PRBS_SEED;
    end else if (chk_valid) begin
      chk_prbs <= chk_step[6:0];
    end
  end

  pbpc_counter #(.W(16)) u_byte_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (clear_strobe),
    .inc     (chk_valid),
    .wrap_en (wrap_en),
    .count   (byte_count),
    .ovf     (byte_ovf)
  );

  pbpc_counter #(.W(8)) u_err_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (clear_strobe),
    .inc     (err_inc),
    .wrap_en (wrap_en),
    .count   (err_count),
    .ovf     ()
  );

  pbpc_counter #(.W(16)) u_pkt_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (clear_strobe),
    .inc     (chk_valid & chk_last),
    .wrap_en (wrap_en),
    .count   (pkt_count),
    .ovf     (pkt_ovf)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_byte <= 16'h0000;
      snap_err  <= 8'h00;
      snap_pkt  <= 16'h0000;
    end else if (lock_strobe) begin
      snap_byte <= byte_count;
      snap_err  <= err_count;
      snap_pkt  <= pkt_count;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  wire ar_take    = arvalid & arready;
  wire ar_aligned = (araddr[1:0] == 2'h0) & (araddr[31:10] == 22'h0);
  wire [7:0] ar_idx = araddr[9:2];

  wire [15:0] status_word = {5'h00, pkt_ovf, byte_ovf, 1'b0, snap_err};

  wire hit_ctl  = ar_aligned & (ar_idx == pbpc_pkg::IDX_CONTROL);
  wire hit_byte = ar_aligned & (ar_idx == pbpc_pkg::IDX_BYTE_COUNT);
  wire hit_sts  = ar_aligned & (ar_idx == pbpc_pkg::IDX_STATUS);
  wire hit_pkt  = ar_aligned & (ar_idx == pbpc_pkg::IDX_PKT_COUNT);
  wire hit_len  = ar_aligned & (ar_idx == pbpc_pkg::IDX_PKT_LEN);
  wire hit_gap  = ar_aligned & (ar_idx == pbpc_pkg::IDX_GAP_LEN);
  wire ar_hit   = hit_ctl | hit_byte | hit_sts | hit_pkt | hit_len | hit_gap;

  wire [15:0] rd_word = hit_ctl  ? {14'h0000, control} :
                        hit_byte ? snap_byte :
                        hit_sts  ? status_word :
                        hit_pkt  ? snap_pkt :
                        hit_len  ? pkt_len :
                        hit_gap  ? {8'h00, gap_len} : 16'h0000;

  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= pbpc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rd_word};
      rresp  <= ar_hit ? pbpc_pkg::RESP_OKAY : pbpc_pkg::RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Packet generator
  // ---------------------------------------------------------------------------
  pbpc_pkg::pbpc_gen_state_t state;
  pbpc_pkg::pbpc_gen_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [6:0]  gen_prbs;
  logic [6:0]  next_gen_prbs;
  logic [7:0]  cur;
  logic [7:0]  next_cur;
  logic [4:0]  word;

  pbpc_stream_if #(.W(5)) gen_in ();
  pbpc_stream_if #(.W(5)) gen_out ();

  wire        gen_en   = control[pbpc_pkg::CTL_GEN_EN_BIT];
  wire        take     = gen_in.valid & gen_in.ready;
  wire [14:0] gen_step = pbpc_pkg::pbpc_prbs_step(gen_prbs);
  wire [15:0] gap_nibbles = 16'(16'(gap_len) * pbpc_pkg::GAP_BYTES_UNIT *
                                pbpc_pkg::NIBBLES_PER_BYTE);

  always_comb begin
    case (state)
      pbpc_pkg::GEN_PRE:    word = {1'b1, pbpc_pkg::PREAMBLE_NIBBLE};
      pbpc_pkg::GEN_SFD_LO: word = {1'b1, pbpc_pkg::SFD_BYTE[3:0]};
      pbpc_pkg::GEN_SFD_HI: word = {1'b1, pbpc_pkg::SFD_BYTE[7:4]};
      pbpc_pkg::GEN_PAY_LO: word = {1'b1, cur[3:0]};
      pbpc_pkg::GEN_PAY_HI: word = {1'b1, cur[7:4]};
      default:              word = 5'h00;
    endcase
  end

  assign gen_in.valid = (state != pbpc_pkg::GEN_IDLE);
  assign gen_in.data  = word;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_gen_prbs = gen_prbs;
    next_cur      = cur;
    case (state)
      pbpc_pkg::GEN_IDLE: begin
        if (gen_en) begin
          next_state    = pbpc_pkg::GEN_PRE;
          next_cnt      = 16'h0000;
          next_gen_prbs = pbpc_pkg::PRBS_SEED;
        end
      end
      pbpc_pkg::GEN_PRE: begin
        if (take) begin
          next_cnt = 16'(cnt + 16'h0001);
          if (cnt == 16'(pbpc_pkg::PREAMBLE_NIBBLES - 16'h0001)) begin
            next_state = pbpc_pkg::GEN_SFD_LO;
          end
        end
      end
      pbpc_pkg::GEN_SFD_LO: begin
        if (take) begin
          next_state = pbpc_pkg::GEN_SFD_HI;
        end
      end
      pbpc_pkg::GEN_SFD_HI, pbpc_pkg::GEN_PAY_HI: begin
        if (take) begin
          if ((state == pbpc_pkg::GEN_SFD_HI) ? (pkt_len == 16'h0000) : (cnt == 16'h0000)) begin
            next_cnt   = 16'(gap_nibbles - 16'h0001);
            next_state = (gap_len != 8'h00) ? pbpc_pkg::GEN_GAP :
                         (gen_en ? pbpc_pkg::GEN_PRE : pbpc_pkg::GEN_IDLE);
            next_gen_prbs = pbpc_pkg::PRBS_SEED;
            if (gap_len == 8'h00) begin
              next_cnt = 16'h0000;
            end
          end else begin
            next_cnt      = (state == pbpc_pkg::GEN_SFD_HI) ? 16'(pkt_len - 16'h0001) :
                                                              16'(cnt - 16'h0001);
            next_cur      = gen_step[14:7];
            next_gen_prbs = gen_step[6:0];
            next_state    = pbpc_pkg::GEN_PAY_LO;
          end
        end
      end
      pbpc_pkg::GEN_PAY_LO: begin
        if (take) begin
          next_state = pbpc_pkg::GEN_PAY_HI;
        end
      end
      pbpc_pkg::GEN_GAP: begin
        if (take) begin
          next_cnt = 16'(cnt - 16'h0001);
          if (cnt == 16'h0000) begin
            // Next preamble counts from zero, not from the wrapped gap count
            next_cnt   = 16'h0000;
            next_state = gen_en ? pbpc_pkg::GEN_PRE : pbpc_pkg::GEN_IDLE;
          end
        end
      end
      default: begin
        next_state = pbpc_pkg::GEN_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= pbpc_pkg::GEN_IDLE;
      cnt      <= 16'h0000;
      gen_prbs <= pbpc_pkg::PRBS_SEED;
      cur      <= 8'h00;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      gen_prbs <= next_gen_prbs;
      cur      <= next_cur;
    end
  end

  // Receiver stalls back up through the buffer into the generator
  pbpc_buf2 #(.W(5)) u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .up      (gen_in),
    .dn      (gen_out)
  );

  assign gen_valid     = gen_out.valid;
  assign gen_out.ready = gen_ready;
  assign gen_frame     = gen_out.data[4];
  assign gen_data      = gen_out.data[3:0];

endmodule : pbpc_bist_ctrl

// File: pbpc_bist_ctrl_monitor.sv
// Port-level assertions for the BIST packet control block
`timescale 1ns/10ps
module pbpc_bist_ctrl_monitor (
  input wire logic        aclk,      // Clock
  input wire logic        aresetn,   // Reset, low
  input wire logic        awvalid,   // Aw valid
  input wire logic        awready,   // Aw ready
  input wire logic        wvalid,    // W valid
  input wire logic        wready,    // W ready
  input wire logic [1:0]  bresp,     // B code
  input wire logic        bvalid,    // B valid
  input wire logic        bready,    // B ready
  input wire logic [31:0] araddr,    // Ar address
  input wire logic        arvalid,   // Ar valid
  input wire logic        arready,   // Ar ready
  input wire logic [31:0] rdata,     // R data
  input wire logic [1:0]  rresp,     // R code
  input wire logic        rvalid,    // R valid
  input wire logic        rready,    // R ready
  input wire logic        gen_valid, // Nibble valid
  input wire logic        gen_ready, // Nibble taken
  input wire logic [3:0]  gen_data,  // Nibble
  input wire logic        gen_frame  // In frame
);
  localparam logic [31:0] STS_ADDR = {22'h0, pbpc_pkg::IDX_STATUS, 2'h0};
  logic rd_sts;

  always_ff @(posedge aclk) begin
    if (arvalid && arready) begin
      rd_sts <= (araddr == STS_ADDR);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_write_stall: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  a_bad_addr: assert property (arvalid && arready && araddr > 32'h3FF |=>
    rresp == pbpc_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read answered");
  a_status_bits: assert property (rvalid && rd_sts |-> rdata[31:11] == 21'h0 && !rdata[8])
    else $error("status reserved bits set");
  a_stall_hold: assert property (gen_valid && !gen_ready |=>
    gen_valid && $stable({gen_frame, gen_data}))
    else $error("nibble lost in stall");
  a_gap_zero: assert property (gen_valid && !gen_frame |-> gen_data == 4'h0)
    else $error("gap nibble not idle");

  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready && rd_sts);
  c_sfd: cover property (gen_valid && gen_ready && gen_frame && gen_data == 4'hD);
endmodule : pbpc_bist_ctrl_monitor

bind pbpc_bist_ctrl pbpc_bist_ctrl_monitor pbpc_bist_ctrl_monitor_i (.*);

// File: pbpc_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module pbpc_buf2 #(
  parameter int W = 5
) (
  input  wire logic  aclk,    // Clock
  input  wire logic  aresetn, // Synchronous reset, low
  pbpc_stream_if.snk up,      // Filling side
  pbpc_stream_if.src dn       // Draining side
);

  logic [W-1:0] mem [2];
  logic         wptr;
  logic         rptr;
  logic [1:0]   fill;

  wire push = up.valid & up.ready;
  wire pop  = dn.valid & dn.ready;
  wire [1:0] next_fill = 2'(fill + {1'b0, push} - {1'b0, pop});

  assign up.ready = (fill != 2'h2);
  assign dn.valid = (fill != 2'h0);
  assign dn.data  = mem[rptr];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wptr   <= 1'b0;
      rptr   <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) begin
        mem[wptr] <= up.data;
      end
      wptr <= wptr ^ push;
      rptr <= rptr ^ pop;
      fill <= next_fill;
    end
  end

endmodule : pbpc_buf2

// File: pbpc_counter.sv
// Checker event counter with saturate or wrap mode and sticky overflow flag
`timescale 1ns/10ps
module pbpc_counter #(
  parameter int W = 16
) (
  input  wire logic         aclk,    // Clock
  input  wire logic         aresetn, // Synchronous reset, low
  input  wire logic         clear,   // Clear count and flag
  input  wire logic         inc,     // Count one event
  input  wire logic         wrap_en, // One: wrap, zero: saturate
  output logic [W-1:0]      count,   // Live count
  output logic              ovf      // Sticky overflow flag
);

  wire          at_max = &count;
  wire          set_ovf = inc & at_max;
  wire [W-1:0]  one = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0]  bumped = at_max ? (wrap_en ? {W{1'b0}} : count) : W'(count + one);
  wire [W-1:0]  next_count = clear ? (inc ? one : {W{1'b0}}) : (inc ? bumped : count);
  wire          next_ovf = set_ovf | (ovf & ~clear);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= {W{1'b0}};
      ovf   <= 1'b0;
    end else begin
      count <= next_count;
      ovf   <= next_ovf;
    end
  end

endmodule : pbpc_counter

// File: pbpc_pkg.sv
// Shared constants, types and the PRBS step function of the BIST packet control block
package pbpc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_CONTROL      = 8'h16;
  localparam logic [7:0]  IDX_BYTE_COUNT   = 8'h71;
  localparam logic [7:0]  IDX_STATUS       = 8'h72;
  localparam logic [7:0]  IDX_PKT_COUNT    = 8'h73;
  localparam logic [7:0]  IDX_PKT_LEN      = 8'h7B;
  localparam logic [7:0]  IDX_GAP_LEN      = 8'h7C;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          STS_LOCK_BIT     = 0;
  localparam int          STS_CLEAR_BIT    = 1;
  localparam int          STS_BYTE_OVF_BIT = 9;
  localparam int          STS_PKT_OVF_BIT  = 10;
  localparam int          CTL_MODE_BIT     = 0;
  localparam int          CTL_GEN_EN_BIT   = 1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] PKT_LEN_RST      = 16'h05DC;
  localparam logic [7:0]  GAP_LEN_RST      = 8'h7D;
  localparam logic [1:0]  CONTROL_RST      = 2'h0;

  // ---------------------------------------------------------------------------
  // Frame format
  // ---------------------------------------------------------------------------
  localparam logic [15:0] PREAMBLE_NIBBLES = 16'h000D;
  localparam logic [3:0]  PREAMBLE_NIBBLE  = 4'h5;
  localparam logic [7:0]  SFD_BYTE         = 8'hD5;
  localparam logic [15:0] GAP_BYTES_UNIT   = 16'h0004;
  localparam logic [15:0] NIBBLES_PER_BYTE = 16'h0002;
  localparam logic [6:0]  PRBS_SEED        = 7'h7F;

  // ---------------------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    GEN_IDLE,
    GEN_PRE,
    GEN_SFD_LO,
    GEN_SFD_HI,
    GEN_PAY_LO,
    GEN_PAY_HI,
    GEN_GAP
  } pbpc_gen_state_t;

  // Eight steps of x^7+x^6+1; returns {byte, next state}
  function automatic logic [14:0] pbpc_prbs_step(input logic [6:0] s);
    logic [6:0] t;
    logic [7:0] b;
    t = s;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = {b[6:0], t[6]};
      t = {t[5:0], t[6] ^ t[5]};
    end
    return {b, t};
  endfunction : pbpc_prbs_step

endpackage : pbpc_pkg

// File: pbpc_stream_if.sv
// Valid/ready stream carrier between the generator and its buffer
`timescale 1ns/10ps
interface pbpc_stream_if #(
  parameter int W = 5
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pbpc_stream_if

// File: test_pbpc_bist_ctrl.sv
// Self-checking bench for the BIST packet control block
`timescale 1ns/10ps
module test_pbpc_bist_ctrl;
  logic        aclk = 1'h0, aresetn = 1'h0, stall = 1'h1, mode = 1'h0, fb = 1'h0, fp = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        gen_ready = 1'h0, chk_valid = 1'h0, chk_first = 1'h0, chk_last = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'h0000D669;
  logic [3:0]  wstrb = 4'h0;
  logic [7:0]  chk_data = 8'h0, ee = 8'h0, se = 8'h0;
  logic        awready, wready, bvalid, arready, rvalid, gen_valid, gen_frame;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [3:0]  gen_data;
  logic [15:0] eb = 16'h0, ep = 16'h0, sb = 16'h0, sp = 16'h0;
  logic [4:0]  got_q[$], exp_q[$];
  int          error_cnt = 0, compares = 0;

  pbpc_bist_ctrl pbpc_bist_ctrl_i (.*);

  always #25 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] A(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction : A

  function automatic logic [7:0] prbs(inout logic [6:0] s);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = {b[6:0], s[6]};
      s = {s[5:0], s[6] ^ s[5]};
    end
    return b;
  endfunction : prbs

  // Receiver with random stalls, records every taken nibble
  always @(posedge aclk) begin
    if (gen_valid === 1'h1 && gen_ready === 1'h1) got_q.push_back({gen_frame, gen_data});
    gen_ready <= ~stall & rnd() > 32'h7FFFFFFF;
  end

  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, dv);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rdc(input logic [31:0] a, exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'h0;
  endtask : rdc

  task automatic send(input int n, input bit bad, input bit each = 1'h0);
    logic [6:0] s;
    logic [7:0] v;
    s = 7'h7F;
    for (int i = 0; i < n; i++) begin
      if (each) s = 7'h7F;
      v = prbs(s);
      if (bad || rnd() < 32'h20000000) begin
        v = v ^ 8'h5A;
        if (mode || ee != 8'hFF) ee++;
      end
      if (eb == 16'hFFFF) fb = 1'h1;
      if (mode || eb != 16'hFFFF) eb++;
      if (each || i == n - 1) begin
        if (ep == 16'hFFFF) fp = 1'h1;
        if (mode || ep != 16'hFFFF) ep++;
      end
      @(posedge aclk);
      chk_valid <= 1'h1;
      chk_first <= each || (i == 0);
      chk_last <= each || (i == n - 1);
      chk_data <= v;
    end
    @(posedge aclk);
    chk_valid <= 1'h0;
  endtask : send

  task automatic lock(input bit clr);
    wr(A(pbpc_pkg::IDX_STATUS), clr ? 32'h2 : 32'h1);
    {sb, se, sp} = {eb, ee, ep};
    if (clr) {eb, ee, ep, fb, fp} = '0;
  endtask : lock

  task automatic snap();
    rdc(A(pbpc_pkg::IDX_BYTE_COUNT), {16'h0, sb}, pbpc_pkg::RESP_OKAY);
    rdc(A(pbpc_pkg::IDX_STATUS), {21'h0, fp, fb, 1'h0, se}, pbpc_pkg::RESP_OKAY);
    rdc(A(pbpc_pkg::IDX_PKT_COUNT), {16'h0, sp}, pbpc_pkg::RESP_OKAY);
  endtask : snap

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [6:0] s;
    logic [7:0] v;
    int L, G;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(A(pbpc_pkg::IDX_PKT_LEN), 32'h05DC, pbpc_pkg::RESP_OKAY);
    rdc(A(pbpc_pkg::IDX_GAP_LEN), 32'h007D, pbpc_pkg::RESP_OKAY);
    snap();
    rdc(32'h400, 32'h0, pbpc_pkg::RESP_SLVERR);
    wr(A(pbpc_pkg::IDX_BYTE_COUNT), 32'h1234);
    chk({30'h0, r}, {30'h0, pbpc_pkg::RESP_SLVERR});
    $display("test registers done");
    L = 1 + rnd() % 4;
    G = 1 + rnd() % 3;
    wr(A(pbpc_pkg::IDX_PKT_LEN), L);
    wr(A(pbpc_pkg::IDX_GAP_LEN), G);
    wr(A(pbpc_pkg::IDX_CONTROL), 32'h2);
    repeat (12) @(posedge aclk);
    chk({31'h0, gen_valid}, 32'h1);
    stall <= 1'h0;
    // Two whole frames, so the preamble after a gap is checked too
    repeat (2) begin
      s = 7'h7F;
      repeat (14) exp_q.push_back(5'h15);
      exp_q.push_back(5'h1D);
      repeat (L) begin
        v = prbs(s);
        exp_q.push_back({1'h1, v[3:0]});
        exp_q.push_back({1'h1, v[7:4]});
      end
      repeat (G * 8) exp_q.push_back(5'h00);
    end
    exp_q.push_back(5'h15);
    for (int i = 0; i < 2000 && got_q.size() < exp_q.size(); i++) @(posedge aclk);
    foreach (exp_q[i]) chk({27'h0, got_q[i]}, {27'h0, exp_q[i]});
    $display("test generator done");
    wr(A(pbpc_pkg::IDX_CONTROL), 32'h0);
    send(20, 1'h0);
    send(300, 1'h1);
    lock(1'h0);
    snap();
    mode = 1'h1;
    wr(A(pbpc_pkg::IDX_CONTROL), 32'h1);
    send(65536, 1'h0, 1'h1);
    lock(1'h0);
    snap();
    send(5, 1'h0);
    snap();
    lock(1'h1);
    snap();
    lock(1'h0);
    snap();
    $display("test counters done");
    complete_run();
  end
endmodule : test_pbpc_bist_ctrl
